/* File: logic/power_supervisor_pkg.sv */
// Constants shared by the power supervisor and its wake capture.
// Assumes byte addresses are four times the register index.
`default_nettype none

package power_supervisor_pkg;

  // Register indices; byte address is index times four
  localparam logic [13:0] IDX_WAKE_STATUS   = 14'h180d;
  localparam logic [13:0] IDX_DETECT_CTRL   = 14'h1800;
  localparam logic [13:0] IDX_POWERDOWN_CTL = 14'h1801;
  localparam logic [13:0] IDX_WARNING_CTRL  = 14'h1802;

  // Detect control fields
  localparam int DET_FLAG_BIT     = 7;
  localparam int DET_ACK_BIT      = 6;
  localparam int DET_IRQ_EN_BIT   = 5;
  localparam int DET_RST_EN_BIT   = 4;
  localparam int DET_STOP_EN_BIT  = 3;
  localparam int DET_LOGIC_EN_BIT = 2;
  localparam int DET_BANDGAP_BIT  = 0;

  // Power-down control fields
  localparam int PD_FLAG_BIT  = 4;
  localparam int PD_ACK_BIT   = 2;
  localparam int PD_ALLOW_BIT = 1;

  // Warning control fields
  localparam int WRN_FLAG_BIT     = 7;
  localparam int WRN_ACK_BIT      = 6;
  localparam int WRN_DET_TRIP_BIT = 5;
  localparam int WRN_WRN_TRIP_BIT = 4;

  // Wake status width: keypad, ext pin, temp, periodic, lf, radio
  localparam int WAKE_W = 6;

  // Reset values
  localparam logic       RST_BIT  = 1'b0;
  localparam logic [5:0] RST_WAKE = 6'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

/* File: logic/wake_status_capture.sv */
// Wake-source status register: captures the waking source on STOP exit.
// Assumes entry and exit strobes are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none

module wake_status_capture (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       stop_entry_i,
  input  wire logic       stop_exit_i,
  input  wire logic [5:0] wake_src_i,
  output logic      [5:0] status_o
);

  logic [5:0] status_r;
  logic [5:0] status_nxt;

  // Exit wins over entry so a same-cycle wake is not lost
  assign status_nxt = stop_exit_i  ? wake_src_i :
                      stop_entry_i ? power_supervisor_pkg::RST_WAKE :
                      status_r;

  // Bus writes never reach this register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= power_supervisor_pkg::RST_WAKE;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status_o = status_r;

  a_wake_entry_clear:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      stop_entry_i && !stop_exit_i |=> status_o == 6'h00)
    else $error("wake status not cleared on stop entry");

  a_wake_held_still:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !stop_entry_i && !stop_exit_i |=> $stable(status_o))
    else $error("wake status changed without stop event");

endmodule

`default_nettype wire

/* File: logic/power_supervisor_wake_status.sv */
// Power supervision registers: undervolt detect, supply warning,
// deep power-down control and wake-source status, on AXI4-Lite.
// Assumes comparator levels and stop strobes are synchronous to clk_i.
//
// What this block does
// - Detect bit 7 reports an undervolt event, meaningful only when enabled.
// - Detect bit 6 write-1 clears the event flag; reads zero.
// - Detect bit 5 enables an interrupt request while the flag is set.
// - Detect bit 4 forces reset when flag set and logic enabled.
// - Detect bit 3 keeps detection running during STOP when enabled.
// - Detect bit 2 enables detect logic; off disables flag, irq, reset.
// - Detect bit 0 enables the bandgap reference buffer.
// - Some detect and power-down bits accept only the first write.
// - Reserved power-down and warning bits read as zero.
// - Power-down bit 4 flags recovery from deepest power-down.
// - Power-down bit 2 write-1 clears the recovery flag.
// - Power-down bit 1 allows deepest power-down on STOP.
// - Warning bit 7 sets when supply is below warning level; sticky.
// - Warning bit 6 write-1 clears flag only if warning gone.
// - Warning bit 5 selects detect trip level, high when one.
// - Warning bit 4 selects warning trip level, high when one.
// - Wake status sits at index 180d and clears on STOP entry.
// - Writes to wake status flags have no effect.
// - Wake bits 5 and 4 record keypad and external pin wake.
// - Wake bits 3..0 record temp, periodic, lf and radio wake.
`timescale 1ns/1ps
`default_nettype none

module power_supervisor_wake_status (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // AXI4-Lite slave
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog and system side
  input  wire logic        undervolt_below_i,
  input  wire logic        supply_warning_below_i,
  input  wire logic        stop_active_i,
  input  wire logic        stop_entry_i,
  input  wire logic        stop_exit_i,
  input  wire logic        deep_sleep_exit_i,
  input  wire logic [5:0]  wake_src_i,
  output logic             undervolt_irq_o,
  output logic             undervolt_reset_o,
  output logic             undervolt_detector_enable_o,
  output logic             bandgap_buffer_enable_o,
  output logic             deep_sleep_allow_o,
  output logic             undervolt_trip_select_o,
  output logic             warning_trip_select_o
);

  // Reset release synchroniser
  logic rst_meta_r;
  logic rst_n_q;
  // Bus handshake state
  logic        awready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  // Control fields
  logic undervolt_irq_enable_r;
  logic undervolt_reset_enable_r;
  logic undervolt_in_stop_enable_r;
  logic undervolt_logic_enable_r;
  logic bandgap_buffer_enable_r;
  logic deep_sleep_allow_r;
  logic undervolt_trip_select_r;
  logic warning_trip_select_r;
  logic detect_locked_r;
  logic powerdown_locked_r;
  // Status flags
  logic undervolt_event_flag_r;
  logic deep_sleep_recovered_flag_r;
  logic supply_warning_flag_r;
  logic [5:0] wake_status;
  // Registered outputs
  logic irq_r;
  logic reset_r;
  logic det_en_r;

  // Asynchronous assert, two-flop release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_q    <= rst_meta_r;
    end
  end

  // Write path: address and data are taken together in one cycle
  wire        wr_go  = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
  wire        wr_hs  = awready_r && s_axi_awvalid && s_axi_wvalid;
  wire [13:0] wr_idx = s_axi_awaddr[15:2];
  wire        wr_lo  = wr_hs && s_axi_wstrb[0];
  wire [7:0]  wd     = s_axi_wdata[7:0];
  wire wr_det_hit = wr_idx == power_supervisor_pkg::IDX_DETECT_CTRL;
  wire wr_pd_hit  = wr_idx == power_supervisor_pkg::IDX_POWERDOWN_CTL;
  wire wr_wrn_hit = wr_idx == power_supervisor_pkg::IDX_WARNING_CTRL;
  wire wr_ws_hit  = wr_idx == power_supervisor_pkg::IDX_WAKE_STATUS;
  wire wr_mapped  = wr_det_hit || wr_pd_hit || wr_wrn_hit || wr_ws_hit;
  wire wr_det = wr_lo && wr_det_hit;
  wire wr_pd  = wr_lo && wr_pd_hit;
  wire wr_wrn = wr_lo && wr_wrn_hit;

  // Acknowledge strobes; ack bits themselves are never stored
  wire det_ack = wr_det && wd[power_supervisor_pkg::DET_ACK_BIT];
  wire pd_ack  = wr_pd  && wd[power_supervisor_pkg::PD_ACK_BIT];
  wire wrn_ack = wr_wrn && wd[power_supervisor_pkg::WRN_ACK_BIT];

  // Read path
  wire        rd_go  = s_axi_arvalid && !arready_r && !rvalid_r;
  wire        rd_hs  = arready_r && s_axi_arvalid;
  wire [13:0] rd_idx = s_axi_araddr[15:2];
  wire rd_det_hit = rd_idx == power_supervisor_pkg::IDX_DETECT_CTRL;
  wire rd_pd_hit  = rd_idx == power_supervisor_pkg::IDX_POWERDOWN_CTL;
  wire rd_wrn_hit = rd_idx == power_supervisor_pkg::IDX_WARNING_CTRL;
  wire rd_ws_hit  = rd_idx == power_supervisor_pkg::IDX_WAKE_STATUS;
  wire rd_mapped  = rd_det_hit || rd_pd_hit || rd_wrn_hit || rd_ws_hit;

  // Flag reads as zero while detection is off; ack and bit 1 read zero
  wire [7:0] det_view = {undervolt_event_flag_r & undervolt_logic_enable_r, 1'b0,
                         undervolt_irq_enable_r, undervolt_reset_enable_r,
                         undervolt_in_stop_enable_r, undervolt_logic_enable_r,
                         1'b0, bandgap_buffer_enable_r};
  wire [7:0] pd_view  = {3'b000, deep_sleep_recovered_flag_r, 1'b0,
                         1'b0, deep_sleep_allow_r, 1'b0};
  wire [7:0] wrn_view = {supply_warning_flag_r, 1'b0,
                         undervolt_trip_select_r, warning_trip_select_r,
                         4'h0};
  wire [7:0] ws_view  = {2'b00, wake_status};
  wire [7:0] rd_byte = rd_det_hit ? det_view :
                       rd_pd_hit  ? pd_view  :
                       rd_wrn_hit ? wrn_view :
                       rd_ws_hit  ? ws_view  : 8'h00;

  // Detector active only when enabled and, in STOP, when stop-enabled
  wire det_active = undervolt_logic_enable_r &&
                    (!stop_active_i || undervolt_in_stop_enable_r);
  wire det_set    = det_active && undervolt_below_i;

  // AXI write channel; response one cycle after the handshake
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= power_supervisor_pkg::RESP_OKAY;
    end else begin
      awready_r <= wr_go;
      if (wr_hs) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_mapped ? power_supervisor_pkg::RESP_OKAY
                              : power_supervisor_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // AXI read channel; data registered at the handshake
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= power_supervisor_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      arready_r <= rd_go;
      if (rd_hs) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_byte};
        rresp_r  <= rd_mapped ? power_supervisor_pkg::RESP_OKAY
                              : power_supervisor_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Detect control; reset, stop and logic enables lock after first write
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      undervolt_irq_enable_r     <= power_supervisor_pkg::RST_BIT;
      undervolt_reset_enable_r   <= power_supervisor_pkg::RST_BIT;
      undervolt_in_stop_enable_r <= power_supervisor_pkg::RST_BIT;
      undervolt_logic_enable_r   <= power_supervisor_pkg::RST_BIT;
      bandgap_buffer_enable_r    <= power_supervisor_pkg::RST_BIT;
      detect_locked_r            <= 1'b0;
    end else if (wr_det) begin
      undervolt_irq_enable_r  <= wd[power_supervisor_pkg::DET_IRQ_EN_BIT];
      bandgap_buffer_enable_r <= wd[power_supervisor_pkg::DET_BANDGAP_BIT];
      detect_locked_r         <= 1'b1;
      if (!detect_locked_r) begin
        undervolt_reset_enable_r   <= wd[power_supervisor_pkg::DET_RST_EN_BIT];
        undervolt_in_stop_enable_r <= wd[power_supervisor_pkg::DET_STOP_EN_BIT];
        undervolt_logic_enable_r   <= wd[power_supervisor_pkg::DET_LOGIC_EN_BIT];
      end
    end
  end

  // Power-down and warning controls; allow bit is write-once
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      deep_sleep_allow_r      <= power_supervisor_pkg::RST_BIT;
      powerdown_locked_r      <= 1'b0;
      undervolt_trip_select_r <= power_supervisor_pkg::RST_BIT;
      warning_trip_select_r   <= power_supervisor_pkg::RST_BIT;
    end else begin
      if (wr_pd) begin
        powerdown_locked_r <= 1'b1;
        if (!powerdown_locked_r) begin
          deep_sleep_allow_r <= wd[power_supervisor_pkg::PD_ALLOW_BIT];
        end
      end
      if (wr_wrn) begin
        undervolt_trip_select_r <= wd[power_supervisor_pkg::WRN_DET_TRIP_BIT];
        warning_trip_select_r   <= wd[power_supervisor_pkg::WRN_WRN_TRIP_BIT];
      end
    end
  end

  // Sticky flags; a set in the ack cycle wins so no event is lost
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      undervolt_event_flag_r      <= power_supervisor_pkg::RST_BIT;
      deep_sleep_recovered_flag_r <= power_supervisor_pkg::RST_BIT;
      supply_warning_flag_r       <= power_supervisor_pkg::RST_BIT;
    end else begin
      if (det_set) begin
        undervolt_event_flag_r <= 1'b1;
      end else if (det_ack) begin
        undervolt_event_flag_r <= 1'b0;
      end
      if (deep_sleep_exit_i) begin
        deep_sleep_recovered_flag_r <= 1'b1;
      end else if (pd_ack) begin
        deep_sleep_recovered_flag_r <= 1'b0;
      end
      if (supply_warning_below_i) begin // Also catches a supply low out of reset
        supply_warning_flag_r <= 1'b1;
      end else if (wrn_ack) begin
        supply_warning_flag_r <= 1'b0;
      end
    end
  end

  // Gated requests toward the core; all qualified by logic enable
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_r    <= 1'b0;
      reset_r  <= 1'b0;
      det_en_r <= 1'b0;
    end else begin
      irq_r    <= undervolt_event_flag_r && undervolt_irq_enable_r &&
                  undervolt_logic_enable_r;
      reset_r  <= undervolt_event_flag_r && undervolt_reset_enable_r &&
                  undervolt_logic_enable_r;
      det_en_r <= det_active;
    end
  end

  wake_status_capture wake_status_capture_inst (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_q),
    .stop_entry_i (stop_entry_i),
    .stop_exit_i  (stop_exit_i),
    .wake_src_i   (wake_src_i),
    .status_o     (wake_status)
  );

  // Port drive
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = awready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign undervolt_irq_o             = irq_r;
  assign undervolt_reset_o           = reset_r;
  assign undervolt_detector_enable_o = det_en_r;
  assign bandgap_buffer_enable_o     = bandgap_buffer_enable_r;
  assign deep_sleep_allow_o          = deep_sleep_allow_r;
  assign undervolt_trip_select_o     = undervolt_trip_select_r;
  assign warning_trip_select_o       = warning_trip_select_r;

  a_flag_ack_clear:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      det_ack && !det_set |=> !undervolt_event_flag_r)
    else $error("undervolt flag not cleared by ack");
  a_flag_sticky_hold:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      undervolt_event_flag_r && !det_ack |=> undervolt_event_flag_r)
    else $error("undervolt flag dropped without ack");
  a_irq_follows_flag:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      undervolt_event_flag_r && undervolt_irq_enable_r &&
      undervolt_logic_enable_r |=> undervolt_irq_o)
    else $error("interrupt missing for set flag");
  a_reset_needs_enable:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      !undervolt_logic_enable_r |=> !undervolt_reset_o && !undervolt_irq_o)
    else $error("request while detect logic off");
  a_reset_on_flag:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      undervolt_event_flag_r && undervolt_reset_enable_r &&
      undervolt_logic_enable_r |=> undervolt_reset_o)
    else $error("reset missing for set flag");
  a_stop_gates_detect:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      stop_active_i && !undervolt_in_stop_enable_r |=> !undervolt_detector_enable_o)
    else $error("detector on in stop without stop enable");
  a_write_once_lock:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      detect_locked_r && wr_det |=> $stable(undervolt_logic_enable_r) &&
      $stable(undervolt_reset_enable_r))
    else $error("write-once detect bit changed");
  a_pd_allow_once:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      powerdown_locked_r |=> $stable(deep_sleep_allow_r))
    else $error("write-once allow bit changed");
  a_warn_ack_blocked:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      supply_warning_below_i |=> supply_warning_flag_r)
    else $error("warning flag clear while warning present");
  a_recover_flag_set:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      deep_sleep_exit_i |=> deep_sleep_recovered_flag_r)
    else $error("recovery flag not set on exit");
  a_write_resp_time:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      wr_hs |=> s_axi_bvalid &&
      ((s_axi_bresp == power_supervisor_pkg::RESP_SLVERR) != $past(wr_mapped)))
    else $error("write response late or wrong");
  a_reserved_read_zero:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      rd_hs && rd_pd_hit |=> (s_axi_rdata & 32'hffff_ffed) == 32'h0000_0000)
    else $error("reserved power-down bits read nonzero");
  a_warn_reserved_zero:
    assert property (@(posedge clk_i) disable iff (!rst_n_q)
      rd_hs && rd_wrn_hit |=> (s_axi_rdata & 32'hffff_ff4f) == 32'h0000_0000)
    else $error("reserved warning bits read nonzero");

endmodule

`default_nettype wire

/* File: verification/power_supervisor_wake_status_bench.sv */
// Self-checking bench for the power supervisor register block.
// Assumes an AXI4-Lite slave with one write and one read in flight.
`timescale 1ns/1ps
`default_nettype none

module power_supervisor_wake_status_bench;
  logic        clk_i;
  logic        nrst_i;
  logic [15:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [15:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        undervolt_below_i;
  logic        supply_warning_below_i;
  logic        stop_active_i;
  logic        stop_entry_i;
  logic        stop_exit_i;
  logic        deep_sleep_exit_i;
  logic [5:0]  wake_src_i;
  logic        undervolt_irq_o;
  logic        undervolt_reset_o;
  logic        undervolt_detector_enable_o;
  logic        bandgap_buffer_enable_o;
  logic        deep_sleep_allow_o;
  logic        undervolt_trip_select_o;
  logic        warning_trip_select_o;
  int          mismatches;
  int          comparisons;
  logic [31:0] rd;
  logic [1:0]  rsp;

  // Byte addresses are the register index shifted by two
  localparam logic [15:0] A_DET  = {power_supervisor_pkg::IDX_DETECT_CTRL, 2'b00};
  localparam logic [15:0] A_PD   = {power_supervisor_pkg::IDX_POWERDOWN_CTL, 2'b00};
  localparam logic [15:0] A_WRN  = {power_supervisor_pkg::IDX_WARNING_CTRL, 2'b00};
  localparam logic [15:0] A_WAKE = {power_supervisor_pkg::IDX_WAKE_STATUS, 2'b00};

  power_supervisor_wake_status power_supervisor_wake_status_inst (.*);

  // Free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Ready flags are sampled at the edge, before that edge's updates land
  // Waits have no limit of their own; the watchdog ends a hang
  task automatic axi_write(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // Read a register and compare its full 32-bit word
  task automatic expect_reg(input logic [15:0] a, input logic [31:0] exp);
    axi_read(a, rd, rsp);
    check(rd, exp);
    check({30'h0, rsp}, {30'h0, power_supervisor_pkg::RESP_OKAY});
  endtask

  task automatic test_reset_and_unmapped();
    expect_reg(A_DET, 32'h00000000);
    expect_reg(A_PD, 32'h00000000);
    expect_reg(A_WRN, 32'h00000000);
    expect_reg(A_WAKE, 32'h00000000);
    axi_read(16'h6010, rd, rsp);
    check({30'h0, rsp}, {30'h0, power_supervisor_pkg::RESP_SLVERR});
    check(rd, 32'h00000000);
    axi_write(16'h6010, 8'hff, rsp);
    check({30'h0, rsp}, {30'h0, power_supervisor_pkg::RESP_SLVERR});
  endtask

  // Dip before enabling must not raise the flag; after enabling it must
  task automatic test_detect();
    undervolt_below_i <= 1'b1;
    @(posedge clk_i);
    undervolt_below_i <= 1'b0;
    axi_write(A_DET, 8'h3c, rsp);
    expect_reg(A_DET, 32'h0000003c);
    check({31'h0, undervolt_detector_enable_o}, 32'h1);
    undervolt_below_i <= 1'b1;
    @(posedge clk_i);
    undervolt_below_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    expect_reg(A_DET, 32'h000000bc);
    expect_reg(A_DET, 32'h000000bc);
    check({31'h0, undervolt_irq_o}, 32'h1);
    check({31'h0, undervolt_reset_o}, 32'h1);
    // Ack, drop irq enable, try to unlock write-once bits, set bandgap
    axi_write(A_DET, 8'h41, rsp);
    repeat (3) @(posedge clk_i);
    expect_reg(A_DET, 32'h0000001d);
    check({31'h0, bandgap_buffer_enable_o}, 32'h1);
    check({31'h0, undervolt_irq_o}, 32'h0);
    check({31'h0, undervolt_reset_o}, 32'h0);
    stop_active_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({31'h0, undervolt_detector_enable_o}, 32'h1);
    stop_active_i <= 1'b0;
  endtask

  task automatic test_warning();
    supply_warning_below_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    expect_reg(A_WRN, 32'h00000080);
    axi_write(A_WRN, 8'h7f, rsp);
    expect_reg(A_WRN, 32'h000000b0);
    check({31'h0, undervolt_trip_select_o}, 32'h1);
    check({31'h0, warning_trip_select_o}, 32'h1);
    supply_warning_below_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    expect_reg(A_WRN, 32'h000000b0);
    axi_write(A_WRN, 8'h40, rsp);
    expect_reg(A_WRN, 32'h00000000);
    check({31'h0, undervolt_trip_select_o}, 32'h0);
    check({31'h0, warning_trip_select_o}, 32'h0);
  endtask

  task automatic test_power_down();
    deep_sleep_exit_i <= 1'b1;
    @(posedge clk_i);
    deep_sleep_exit_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    expect_reg(A_PD, 32'h00000010);
    axi_write(A_PD, 8'hef, rsp);
    check({30'h0, rsp}, {30'h0, power_supervisor_pkg::RESP_OKAY});
    expect_reg(A_PD, 32'h00000002);
    check({31'h0, deep_sleep_allow_o}, 32'h1);
    axi_write(A_PD, 8'h00, rsp);
    expect_reg(A_PD, 32'h00000002);
  endtask

  // Source changes after the exit pulse must not leak into the status
  task automatic wake_cycle(input logic [5:0] src);
    wake_src_i  <= src;
    stop_exit_i <= 1'b1;
    @(posedge clk_i);
    stop_exit_i <= 1'b0;
    wake_src_i  <= ~src;
    repeat (3) @(posedge clk_i);
    expect_reg(A_WAKE, {26'h0, src});
    axi_write(A_WAKE, 8'h3f, rsp);
    expect_reg(A_WAKE, {26'h0, src});
    stop_entry_i <= 1'b1;
    @(posedge clk_i);
    stop_entry_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    expect_reg(A_WAKE, 32'h00000000);
  endtask

  // Second reset: stop gating off, interrupt and reset off, flag polled
  task automatic test_stop_gating();
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    expect_reg(A_DET, 32'h00000000);
    axi_write(A_DET, 8'h04, rsp);
    stop_active_i     <= 1'b1;
    undervolt_below_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    undervolt_below_i <= 1'b0;
    check({31'h0, undervolt_detector_enable_o}, 32'h0);
    expect_reg(A_DET, 32'h00000004);
    stop_active_i     <= 1'b0;
    undervolt_below_i <= 1'b1;
    @(posedge clk_i);
    undervolt_below_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    expect_reg(A_DET, 32'h00000084);
    check({31'h0, undervolt_irq_o}, 32'h0);
    check({31'h0, undervolt_reset_o}, 32'h0);
    check({31'h0, undervolt_detector_enable_o}, 32'h1);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, far beyond the roughly 160 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end

  // Main sequence; bready and rready stay high throughout
  initial begin
    mismatches = 0;
    comparisons = 0;
    nrst_i = 1'b0;
    s_axi_awaddr = 16'h0000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h1;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 16'h0000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    undervolt_below_i = 1'b0;
    supply_warning_below_i = 1'b0;
    stop_active_i = 1'b0;
    stop_entry_i = 1'b0;
    stop_exit_i = 1'b0;
    deep_sleep_exit_i = 1'b0;
    wake_src_i = 6'h00;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    test_reset_and_unmapped();
    test_detect();
    test_warning();
    test_power_down();
    wake_cycle(6'h2a);
    wake_cycle(6'h15);
    test_stop_gating();
    finish_test();
  end
endmodule

`default_nettype wire
